/* File: rtl/spq_pkg.sv */
package spq_pkg;
    localparam int          LANES      = 4;
    localparam int          BYTE_BITS  = 8;
    localparam logic [3:0]  OE_NONE    = 4'h0;
    localparam logic [3:0]  OE_SINGLE  = 4'h2;
    localparam logic [3:0]  OE_QUAD    = 4'hF;
    localparam logic [3:0]  STEP_ONE   = 4'h1;
    localparam logic [3:0]  STEP_QUAD  = 4'h4;
    localparam logic [7:0]  BYTE_RST   = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_PAUSE = 2'b10
    } spq_state_t;

    typedef struct packed {
        spq_state_t  state;
        logic        sck_s1;
        logic        sck_s2;
        logic        sck_d;
        logic        cs_s1;
        logic        cs_s2;
        logic [3:0]  ln_s1;
        logic [3:0]  ln_s2;
        logic [3:0]  rx_cnt;
        logic [3:0]  tx_cnt;
        logic [7:0]  rx_sh;
        logic [7:0]  tx_sh;
        logic [7:0]  rx_byte;
        logic        rx_valid;
        logic        tx_req;
        logic [3:0]  out;
        logic [3:0]  oe;
        logic        busy;
    } spq_regs_t;
endpackage : spq_pkg

/* File: rtl/spq_lane3.sv */
`timescale 1ns/10ps
`default_nettype none
module spq_lane3 (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        SCK,
    input  wire logic        CS_N,
    input  wire logic [2:0]  LANE_IN,
    input  wire logic        LANE3_IN,
    output logic             LANE3_OUT,
    output logic             LANE3_OE,
    output logic             LANE3_PULLUP,
    output logic [2:0]       LANE_OUT,
    output logic [2:0]       LANE_OE,
    input  wire logic        QUAD_PROG,
    input  wire logic        QUAD_READ,
    input  wire logic        BUSY_IN,
    output logic             BUSY_OUT,
    output logic             STANDBY,
    output logic             PAUSED,
    input  wire logic [7:0]  TX_DATA,
    output logic             TX_REQ,
    output logic [7:0]       RX_DATA,
    output logic             RX_VALID
);
    spq_pkg::spq_regs_t r_reg;
    spq_pkg::spq_regs_t r_next;

    logic rise;
    logic fall;
    logic sel;
    logic pause_req;
    logic [3:0] rstep;
    logic [3:0] tstep;
    logic [3:0] rsum;
    logic [3:0] tsum;

    // edges read the second stage and its delayed copy, never the first
    assign rise      = r_reg.sck_s2 & ~r_reg.sck_d;
    assign fall      = ~r_reg.sck_s2 & r_reg.sck_d;
    assign sel       = ~r_reg.cs_s2;
    // the pin is a data lane during quad commands, so it cannot pause then
    assign pause_req = ~r_reg.ln_s2[3] & ~(QUAD_PROG | QUAD_READ);
    assign rstep     = QUAD_PROG ? spq_pkg::STEP_QUAD : spq_pkg::STEP_ONE;
    assign tstep     = QUAD_READ ? spq_pkg::STEP_QUAD : spq_pkg::STEP_ONE;
    assign rsum      = r_reg.rx_cnt + rstep;
    assign tsum      = r_reg.tx_cnt + tstep;

    always_comb begin
        r_next          = r_reg;
        r_next.sck_s1   = SCK;
        r_next.sck_s2   = r_reg.sck_s1;
        r_next.sck_d    = r_reg.sck_s2;
        r_next.cs_s1    = CS_N;
        r_next.cs_s2    = r_reg.cs_s1;
        r_next.ln_s1    = {LANE3_IN, LANE_IN};
        r_next.ln_s2    = r_reg.ln_s1;
        r_next.rx_valid = 1'b0;
        r_next.tx_req   = 1'b0;
        r_next.busy     = BUSY_IN;
        case (r_reg.state)
            spq_pkg::ST_IDLE: begin
                r_next.oe = spq_pkg::OE_NONE;
                if (sel) begin
                    r_next.state  = spq_pkg::ST_SHIFT;
                    r_next.rx_cnt = 4'h0;
                    r_next.tx_cnt = 4'h0;
                    r_next.tx_sh  = TX_DATA;
                end
            end
            spq_pkg::ST_SHIFT: begin
                if (!sel) begin
                    r_next.state = spq_pkg::ST_IDLE;
                    r_next.oe    = spq_pkg::OE_NONE;
                end else if (pause_req && !r_reg.sck_s2) begin
                    // counters and shifters are left alone so the transfer resumes
                    r_next.state = spq_pkg::ST_PAUSE;
                    r_next.oe    = spq_pkg::OE_NONE;
                end else begin
                    // quad read drives every lane and wins over quad program, which keeps every lane an input
                    if (QUAD_READ)
                        r_next.oe = spq_pkg::OE_QUAD;
                    else if (QUAD_PROG)
                        r_next.oe = spq_pkg::OE_NONE;
                    else
                        r_next.oe = spq_pkg::OE_SINGLE;
                    if (rise) begin
                        if (QUAD_PROG)
                            r_next.rx_sh = {r_reg.rx_sh[3:0], r_reg.ln_s2};
                        else
                            r_next.rx_sh = {r_reg.rx_sh[6:0], r_reg.ln_s2[0]};
                        r_next.rx_cnt = {1'b0, rsum[2:0]};
                        if (rsum[3]) begin
                            r_next.rx_valid = 1'b1;
                            r_next.rx_byte  = r_next.rx_sh;
                        end
                    end
                    if (fall) begin
                        if (QUAD_READ) begin
                            r_next.out   = r_reg.tx_sh[7:4];
                            r_next.tx_sh = {r_reg.tx_sh[3:0], 4'h0};
                        end else begin
                            r_next.out   = {2'b00, r_reg.tx_sh[7], 1'b0};
                            r_next.tx_sh = {r_reg.tx_sh[6:0], 1'b0};
                        end
                        r_next.tx_cnt = {1'b0, tsum[2:0]};
                        if (tsum[3]) begin
                            r_next.tx_sh  = TX_DATA;
                            r_next.tx_req = 1'b1;
                        end
                    end
                end
            end
            spq_pkg::ST_PAUSE: begin
                // clock edges and lane values fall through untouched
                r_next.oe = spq_pkg::OE_NONE;
                if (!sel)
                    r_next.state = spq_pkg::ST_IDLE;
                else if (r_reg.ln_s2[3] && !r_reg.sck_s2)
                    r_next.state = spq_pkg::ST_SHIFT;
            end
            default: begin
                r_next.state = spq_pkg::ST_IDLE;
                r_next.oe    = spq_pkg::OE_NONE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            r_reg          <= '0;
            r_reg.state    <= spq_pkg::ST_IDLE;
            r_reg.sck_s1   <= 1'b0;
            r_reg.cs_s1    <= 1'b1;
            r_reg.cs_s2    <= 1'b1;
            r_reg.ln_s1    <= spq_pkg::OE_QUAD;
            r_reg.ln_s2    <= spq_pkg::OE_QUAD;
            r_reg.rx_sh    <= spq_pkg::BYTE_RST;
            r_reg.tx_sh    <= spq_pkg::BYTE_RST;
            r_reg.rx_byte  <= spq_pkg::BYTE_RST;
            r_reg.oe       <= spq_pkg::OE_NONE;
        end else begin
            r_reg <= r_next;
        end
    end

    assign LANE3_OUT    = r_reg.out[3];
    assign LANE3_OE     = r_reg.oe[3];
    // pull-up enable; the wire model resolves an undriven pin to high
    assign LANE3_PULLUP = 1'b1;
    assign LANE_OUT     = r_reg.out[2:0];
    assign LANE_OE      = r_reg.oe[2:0];
    assign BUSY_OUT     = r_reg.busy;
    assign STANDBY      = r_reg.cs_s2 & ~r_reg.busy;
    assign PAUSED       = (r_reg.state == spq_pkg::ST_PAUSE);
    assign TX_REQ       = r_reg.tx_req;
    assign RX_DATA      = r_reg.rx_byte;
    assign RX_VALID     = r_reg.rx_valid;

    property p_pause_hiz;
        @(posedge CLK) disable iff (!RESET_N)
        (r_reg.state == spq_pkg::ST_PAUSE) |-> (r_reg.oe == spq_pkg::OE_NONE);
    endproperty
    a_pause_hiz: assert property (p_pause_hiz) else $error("outputs driven during pause");

    property p_pause_keep;
        @(posedge CLK) disable iff (!RESET_N)
        (r_reg.state == spq_pkg::ST_PAUSE) |=> $stable(r_reg.rx_sh) && $stable(r_reg.rx_cnt) && $stable(r_reg.tx_sh);
    endproperty
    a_pause_keep: assert property (p_pause_keep) else $error("shift state changed in pause");

    property p_busy;
        @(posedge CLK) disable iff (!RESET_N)
        PAUSED |=> (BUSY_OUT == $past(BUSY_IN));
    endproperty
    a_busy: assert property (p_busy) else $error("busy disturbed by pause");

    property p_quad_in;
        @(posedge CLK) disable iff (!RESET_N)
        (r_reg.state == spq_pkg::ST_SHIFT) && sel && rise && QUAD_PROG
        |=> (r_reg.rx_sh[3:0] == $past(r_reg.ln_s2)) && (r_reg.oe == spq_pkg::OE_NONE);
    endproperty
    a_quad_in: assert property (p_quad_in) else $error("quad nibble not captured");

    property p_quad_out;
        @(posedge CLK) disable iff (!RESET_N)
        (r_reg.state == spq_pkg::ST_SHIFT) && sel && fall && QUAD_READ
        |=> (r_reg.out == $past(r_reg.tx_sh[7:4])) && (r_reg.oe == spq_pkg::OE_QUAD);
    endproperty
    a_quad_out: assert property (p_quad_out) else $error("quad nibble not driven");

    property p_lane3_input;
        @(posedge CLK) disable iff (!RESET_N)
        !QUAD_READ |=> !LANE3_OE;
    endproperty
    a_lane3_input: assert property (p_lane3_input) else $error("lane three driven outside quad read");

    property p_deselect;
        @(posedge CLK) disable iff (!RESET_N)
        r_reg.cs_s2 |=> (r_reg.state == spq_pkg::ST_IDLE) && (r_reg.oe == spq_pkg::OE_NONE);
    endproperty
    a_deselect: assert property (p_deselect) else $error("not released on deselect");

    property p_single_in;
        @(posedge CLK) disable iff (!RESET_N)
        (r_reg.state == spq_pkg::ST_SHIFT) && sel && rise && !QUAD_PROG
        |=> (r_reg.rx_sh[0] == $past(r_reg.ln_s2[0]));
    endproperty
    a_single_in: assert property (p_single_in) else $error("serial bit not captured on rise");

    property p_pause_enter;
        @(posedge CLK) disable iff (!RESET_N)
        (r_reg.state == spq_pkg::ST_SHIFT) && sel && pause_req && !r_reg.sck_s2
        |=> (r_reg.state == spq_pkg::ST_PAUSE) ##1 (r_reg.oe == spq_pkg::OE_NONE);
    endproperty
    a_pause_enter: assert property (p_pause_enter) else $error("pause not entered");

    property p_resume;
        @(posedge CLK) disable iff (!RESET_N)
        (r_reg.state == spq_pkg::ST_PAUSE) && sel && r_reg.ln_s2[3] && !r_reg.sck_s2
        |=> (r_reg.state == spq_pkg::ST_SHIFT);
    endproperty
    a_resume: assert property (p_resume) else $error("pause not released");

    c_pause: cover property (@(posedge CLK) disable iff (!RESET_N)
        (r_reg.state == spq_pkg::ST_PAUSE) ##1 (r_reg.state == spq_pkg::ST_SHIFT));
    c_quad_byte: cover property (@(posedge CLK) disable iff (!RESET_N) RX_VALID && QUAD_PROG);
    c_quad_read: cover property (@(posedge CLK) disable iff (!RESET_N) TX_REQ && QUAD_READ);
    c_single_byte: cover property (@(posedge CLK) disable iff (!RESET_N) RX_VALID && !QUAD_PROG);
endmodule : spq_lane3
`default_nettype wire

/* File: tb/spq_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module spq_host_model (
    input  wire logic       CLK,
    output logic            SCK,
    output logic            CS_N,
    output logic [2:0]      LANE_IN,
    output logic            LANE3_IN,
    input  wire logic       LANE3_OUT,
    input  wire logic       LANE3_OE,
    input  wire logic       LANE3_PULLUP,
    input  wire logic [2:0] LANE_OUT,
    input  wire logic [2:0] LANE_OE
);
    logic [3:0] drv_val;
    logic [3:0] drv_oe;
    logic [2:0] pat;
    initial begin
        SCK = 1'b0;
        CS_N = 1'b1;
        drv_val = 4'hF;
        drv_oe = 4'h0;
        pat = 3'h5;
    end
    // released lanes 0 to 2 change every cycle so a stale value never passes for data; a released lane 3 sits at the pull-up
    always @(posedge CLK) pat <= pat + 3'h3;
    assign LANE_IN  = (LANE_OE & LANE_OUT) | (~LANE_OE & ((drv_oe[2:0] & drv_val[2:0]) | (~drv_oe[2:0] & pat)));
    assign LANE3_IN = LANE3_OE ? LANE3_OUT : (drv_oe[3] ? drv_val[3] : LANE3_PULLUP);
    // pins change by non-blocking assignment on a clock edge; four cycles a half gives a 400 ns link clock
    task automatic half;
        repeat (4) @(posedge CLK);
    endtask : half
    task automatic sel(input logic v);
        half();
        CS_N <= v;
        half();
    endtask : sel
    task automatic edge_nib(input logic [3:0] oe, input logic [3:0] v);
        drv_oe  <= oe;
        drv_val <= v;
        half();
        SCK <= ~SCK;
        half();
        SCK <= ~SCK;
    endtask : edge_nib
    // only called with select low and clock low
    task automatic pause(input logic on);
        drv_oe[3]  <= on;
        drv_val[3] <= 1'b0;
        half();
    endtask : pause
endmodule : spq_host_model
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        CLK = 1'b0;
    logic        RESET_N, QUAD_PROG, QUAD_READ, BUSY_IN, SCK, CS_N, LANE3_IN, LANE3_OUT, LANE3_OE, LANE3_PULLUP;
    logic        BUSY_OUT, STANDBY, PAUSED, TX_REQ, RX_VALID, rx_on;
    logic [2:0]  LANE_IN, LANE_OUT, LANE_OE;
    logic [7:0]  TX_DATA, RX_DATA, byt;
    logic [31:0] seed = 32'h00001509;
    logic [31:0] rnd;
    logic [7:0]  exp_q[$];
    int          checks = 0, miscompares = 0, cycles = 0, reqs = 0;
    spq_lane3 DUT (.CLK(CLK), .RESET_N(RESET_N), .SCK(SCK), .CS_N(CS_N), .LANE_IN(LANE_IN), .LANE3_IN(LANE3_IN),
        .LANE3_OUT(LANE3_OUT), .LANE3_OE(LANE3_OE), .LANE3_PULLUP(LANE3_PULLUP), .LANE_OUT(LANE_OUT),
        .LANE_OE(LANE_OE), .QUAD_PROG(QUAD_PROG), .QUAD_READ(QUAD_READ), .BUSY_IN(BUSY_IN), .BUSY_OUT(BUSY_OUT),
        .STANDBY(STANDBY), .PAUSED(PAUSED), .TX_DATA(TX_DATA), .TX_REQ(TX_REQ), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID));
    spq_host_model host (.CLK(CLK), .SCK(SCK), .CS_N(CS_N), .LANE_IN(LANE_IN), .LANE3_IN(LANE3_IN),
        .LANE3_OUT(LANE3_OUT), .LANE3_OE(LANE3_OE), .LANE3_PULLUP(LANE3_PULLUP), .LANE_OUT(LANE_OUT), .LANE_OE(LANE_OE));
    always #25 CLK = ~CLK;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        checks++;
        if (seen !== expv) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, expv);
        end
    endtask : check
    task automatic finish_test;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task automatic set_mode(input logic [1:0] m);
        @(posedge CLK) {QUAD_PROG, QUAD_READ} <= m;
    endtask : set_mode
    // a hang counts as a mismatch and still reaches the verdict
    always @(posedge CLK) begin
        cycles++;
        if (TX_REQ === 1'b1) reqs++;
        if (cycles == 10000) begin
            miscompares++;
            finish_test();
        end
    end
    always @(posedge CLK) begin
        if (rx_on && RX_VALID === 1'b1) begin
            // a byte nobody sent can never match
            check(16'(RX_DATA), exp_q.size() > 0 ? 16'(exp_q[0]) : 16'h0100);
            if (exp_q.size() > 0) void'(exp_q.pop_front());
        end
    end
    initial begin
        RESET_N = 1'b0;
        QUAD_PROG = 1'b0;
        QUAD_READ = 1'b0;
        BUSY_IN = 1'b0;
        TX_DATA = 8'h00;
        rx_on = 1'b1;
        repeat (4) @(posedge CLK);
        check({LANE3_OE, LANE_OE, PAUSED, BUSY_OUT, LANE3_PULLUP}, 7'h01);
        RESET_N <= 1'b1;
        repeat (5) @(posedge CLK);
        check(STANDBY, 1'b1);
        $display("reset test done");
        @(posedge CLK) TX_DATA <= 8'(xs());
        host.sel(1'b0);
        check(STANDBY, 1'b0);
        for (int b = 0; b < 4; b++) begin
            byt = 8'(xs());
            exp_q.push_back(byt);
            for (int i = 7; i >= 0; i--) begin
                if (b == 3 && i == 4) begin
                    host.pause(1'b1);
                    repeat (2) @(posedge CLK);
                    check({PAUSED, LANE3_OE, LANE_OE}, 5'h10);
                    rnd = xs();
                    @(posedge CLK) BUSY_IN <= rnd[0];
                    repeat (3) host.edge_nib(4'h8, {1'b0, 3'(xs())});
                    check({PAUSED, BUSY_OUT, LANE3_OE}, {1'b1, rnd[0], 1'b0});
                    @(posedge CLK) BUSY_IN <= 1'b0;
                    host.pause(1'b0);
                    repeat (4) @(posedge CLK);
                    check({PAUSED, BUSY_OUT, LANE3_OE, LANE_OE}, 5'h02);
                end
                host.edge_nib(4'h1, {3'h0, byt[i]});
                repeat (4) @(posedge CLK);
                check({LANE3_OE, LANE_OE, LANE3_OUT, LANE_OUT}, {4'h2, 2'b00, TX_DATA[i], 1'b0});
            end
        end
        host.sel(1'b1);
        check(16'(exp_q.size()), 16'h0000);
        check(16'(reqs), 16'h0004);
        @(posedge CLK) BUSY_IN <= ~rnd[0];
        repeat (4) @(posedge CLK);
        check({STANDBY, LANE3_OE, LANE_OE}, {rnd[0], 3'h0});
        @(posedge CLK) BUSY_IN <= 1'b0;
        $display("single and pause test done");
        set_mode(2'b10);
        host.sel(1'b0);
        for (int b = 0; b < 3; b++) begin
            byt = 8'(xs());
            exp_q.push_back(byt);
            host.edge_nib(4'hF, byt[7:4]);
            host.edge_nib(4'hF, byt[3:0]);
        end
        host.sel(1'b1);
        check(16'(exp_q.size()), 16'h0000);
        $display("quad program test done");
        rx_on = 1'b0;
        set_mode(2'b01);
        @(posedge CLK) TX_DATA <= 8'(xs());
        host.sel(1'b0);
        reqs = 0;
        host.edge_nib(4'h0, 4'h0);
        repeat (6) @(posedge CLK);
        check({LANE3_OE, LANE_OE, LANE3_OUT, LANE_OUT}, {4'hF, TX_DATA[7:4]});
        host.edge_nib(4'h0, 4'h0);
        repeat (6) @(posedge CLK);
        check({LANE3_OE, LANE_OE, LANE3_OUT, LANE_OUT}, {4'hF, TX_DATA[3:0]});
        check(16'(reqs), 16'h0001);
        host.sel(1'b1);
        check({LANE3_OE, LANE_OE}, 4'h0);
        $display("quad read test done");
        // reset in mid-run clears the received byte and every strobe
        @(posedge CLK) RESET_N <= 1'b0;
        repeat (2) @(posedge CLK);
        check({RX_DATA, RX_VALID, TX_REQ, PAUSED, LANE3_OE, LANE_OE}, 15'h0000);
        @(posedge CLK) RESET_N <= 1'b1;
        repeat (3) @(posedge CLK);
        check({STANDBY, PAUSED}, 2'h2);
        $display("mid-run reset test done");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
